// file: dv/cid_fsk_if_bench.sv
// Purpose: self-checking bench for the caller data interface
// Assumes: short sim counts 16, 8, 20, 20
// Notes: registers reached over apb, host model shifts words
`timescale 1ns/1ps
`default_nettype none
module cid_fsk_if_bench
    import cid_pkg::*;
;
    localparam int BC = 16;
    localparam int HC = 8;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic demod_bit, carrier_raw, tone_raw, guard_threshold, shclk, sclk_o, oe_n;
    logic data_out, flag_n, early, cd_n, hyb, pdown, tmode, sclk_d;
    logic [8:0] w;
    int err_count, n_checks, k, r0;
    int cyc = 0;
    int n_rise = 0;

    cid_fsk_if #(.BIT_CYC(BC), .HALF_CYC(HC), .CD_ON_CYC(20), .CD_OFF_CYC(20)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .demod_bit(demod_bit),
        .carrier_raw(carrier_raw), .tone_raw(tone_raw),
        .guard_threshold(guard_threshold), .bit_shift_clock_i(shclk),
        .bit_shift_clock_o(sclk_o), .bit_shift_clock_oe_n(oe_n),
        .data_out(data_out), .ready_or_tone_flag_n(flag_n),
        .early_tone_flag(early), .carrier_present_n(cd_n),
        .hybrid_amp_select(hyb), .power_down(pdown), .test_mode(tmode));

    cid_host_model u_host (.shift_clk(shclk), .data_in(data_out), .flag_n(flag_n));

    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    always @(posedge pclk)
    begin
        sclk_d <= sclk_o;
        if (sclk_o && !sclk_d)
            n_rise <= n_rise + 1;
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_count++;
            print_verdict();
        end
    end

    task automatic print_verdict;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        q = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // start, eight data bits lsb first, stop; returns mid stop bit
    task automatic frame(input logic [7:0] b, input logic stp, input logic ck0);
        logic [9:0] f;
        f = {stp, b, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            demod_bit <= f[i];
            tick(HC);
            if (ck0) chk(32'(data_out), 32'(f[i]));
            if (i < 9) tick(BC - HC);
        end
    endtask

    task automatic wait_low;
        k = 0;
        while (flag_n !== 1'b0 && k < 60)
        begin
            tick(1);
            k++;
        end
        chk(32'(flag_n), 32'h0);
    endtask

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        demod_bit = 1'b1;
        carrier_raw = 1'b0;
        tone_raw = 1'b0;
        guard_threshold = 1'b0;
        err_count = 0;
        n_checks = 0;
        tick(8);
        presetn <= 1'b1;
        tick(1);
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk(q, 32'(CTRL_RST));
        apb(1'b0, 8'h0c, 32'h0);
        chk(32'(perr), 32'h1);
        for (int c = 0; c < 8; c++)
        begin
            apb(1'b1, ADDR_CTRL, 32'(c));
            chk(32'({hyb, pdown, tmode}), 32'({c == 2 || c == 3, c == 1, c == 0}));
        end
        // bit stream mode
        apb(1'b1, ADDR_CTRL, 32'h6);
        demod_bit <= 1'b0;
        tick(6);
        chk(32'(data_out), 32'h1);
        demod_bit <= 1'b1;
        carrier_raw <= 1'b1;
        tick(30);
        chk(32'({cd_n, oe_n}), 32'h0);
        r0 = n_rise;
        frame(8'ha5, 1'b1, 1'b1);
        wait_low;
        k = 0;
        while (flag_n === 1'b0 && k < 40)
        begin
            tick(1);
            k++;
        end
        chk(32'(k), 32'(HC));
        chk(32'(n_rise - r0 >= 9), 32'h1);
        carrier_raw <= 1'b0;
        tick(5);
        carrier_raw <= 1'b1;
        tick(5);
        chk(32'(cd_n), 32'h0);
        // buffered mode
        apb(1'b1, ADDR_CTRL, 32'h7);
        chk(32'(oe_n), 32'h1);
        frame(8'h3c, 1'b1, 1'b0);
        wait_low;
        u_host.read_bits(9, w);
        chk(32'(w), 32'h13c);
        chk(32'(u_host.first_flag), 32'h1);
        frame(8'h81, 1'b1, 1'b0);
        wait_low;
        u_host.read_bits(3, w);
        frame(8'h5a, 1'b0, 1'b0);
        wait_low;
        demod_bit <= 1'b1;
        apb(1'b0, ADDR_WORD, 32'h0);
        chk(q, 32'h05a);
        u_host.read_bits(9, w);
        chk(32'(w), 32'h05a);
        carrier_raw <= 1'b0;
        tick(30);
        chk(32'(cd_n), 32'h1);
        // hybrid tone while off-hook, then line tone
        for (int c = 3; c < 6; c += 2)
        begin
            apb(1'b1, ADDR_CTRL, 32'(c));
            tone_raw <= 1'b1;
            tick(5);
            chk(32'(early), 32'h1);
            guard_threshold <= 1'b1;
            tick(5);
            chk(32'(flag_n), 32'h0);
            apb(1'b0, ADDR_STATUS, 32'h0);
            chk(q, 32'((1 << ST_EARLY) | (1 << ST_DELAYED)));
            guard_threshold <= 1'b0;
            tone_raw <= 1'b0;
            tick(5);
            chk(32'({early, flag_n}), 32'h1);
        end
        print_verdict();
    end
endmodule
`default_nettype wire

// file: dv/cid_host_model.sv
// Purpose: host side model that shifts buffered words out
// Assumes: shift clock period 160 ns, idles low between words
// Notes: phase is free of pclk; bits read late in the high phase
`timescale 1ns/1ps
`default_nettype none
module cid_host_model
(
    // host pins
    output var logic shift_clk,
    input wire logic data_in,
    input wire logic flag_n
);
    logic first_flag;
    initial
    begin
        shift_clk = 1'b0;
        first_flag = 1'b0;
    end
    // one rising edge per bit, unshifted bits read as 1
    task automatic read_bits(input int n, output logic [8:0] w);
        w = 9'h1ff;
        for (int i = 0; i < n; i++)
        begin
            #7 shift_clk = 1'b1;
            #80 w[i] = data_in;
            shift_clk = 1'b0;
            #40 if (i == 0) first_flag = flag_n;
            #33;
        end
    endtask
endmodule
`default_nettype wire

// file: inc/cid_pkg.sv
// Purpose: shared constants and types for the caller data interface
// Assumes: 50 MHz pclk, 1200 baud demodulated stream
// Notes: long counts are defaults for top-level parameters
package cid_pkg;
    // clock and line timing
    localparam int unsigned CLK_MHZ = 50;
    localparam int unsigned BAUD = 1200;
    localparam int unsigned BIT_CYC_DEF = CLK_MHZ * 1000000 / BAUD;
    localparam int unsigned HALF_CYC_DEF = BIT_CYC_DEF / 2;
    localparam int unsigned CARRIER_ON_US = 8000;
    localparam int unsigned CARRIER_OFF_US = 8000;
    localparam int unsigned CD_ON_CYC_DEF = CARRIER_ON_US * CLK_MHZ;
    localparam int unsigned CD_OFF_CYC_DEF = CARRIER_OFF_US * CLK_MHZ;
    localparam int unsigned CNT_W = 20;
    localparam int unsigned WORD_W = 9;
    // apb register map
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_WORD = 8'h08;
    // control field positions and reset value (power-down)
    localparam int unsigned CTRL_IFSEL = 0;
    localparam int unsigned CTRL_FSA = 1;
    localparam int unsigned CTRL_FSB = 2;
    localparam logic [2:0] CTRL_RST = 3'h1;
    // status field positions
    localparam int unsigned ST_CARRIER = 0;
    localparam int unsigned ST_EARLY = 1;
    localparam int unsigned ST_DELAYED = 2;
    localparam int unsigned ST_READY = 3;
    localparam int unsigned ST_PDOWN = 4;
    localparam int unsigned ST_TEST = 5;
    // synchronised pin positions
    localparam int unsigned PIN_DEMOD = 0;
    localparam int unsigned PIN_CARRIER = 1;
    localparam int unsigned PIN_TONE = 2;
    localparam int unsigned PIN_GUARD = 3;
    localparam int unsigned PIN_SHCLK = 4;
    localparam int unsigned PIN_W = 5;

    typedef enum logic [2:0] {
        FN_DEMOD,
        FN_HYB_TONE,
        FN_LINE_TONE,
        FN_POWER_DOWN,
        FN_TEST
    } cid_func_t;

    typedef struct packed {
        logic function_select_b;
        logic function_select_a;
        logic interface_select;
    } cid_ctrl_t;

    typedef struct packed {
        logic valid;
        logic [WORD_W-1:0] bits;
    } cid_word_t;
endpackage

// file: rtl/cid_bitrx.sv
// Purpose: frames the demodulated stream into start, 8 data and stop bits
// Assumes: rx already synchronised; enable gated by carrier
// Notes: bits sampled at nominal centre, lsb first
`timescale 1ns/1ps
`default_nettype none
module cid_bitrx
    import cid_pkg::*;
#(
    parameter int unsigned BIT_CYC = BIT_CYC_DEF,
    parameter int unsigned HALF_CYC = HALF_CYC_DEF
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // stream
    input wire logic enable,
    input wire logic rx,
    // results
    output logic mid_pulse,
    output cid_word_t word
);
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} cid_rx_t;

    cid_rx_t state_r, state_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic [3:0] nbit_r, nbit_nxt;
    logic [WORD_W-1:0] sr_r, sr_nxt;
    cid_word_t word_r, word_nxt;
    logic mid_r, mid_nxt;

    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r + 1'b1;
        nbit_nxt = nbit_r;
        sr_nxt = sr_r;
        word_nxt = '{valid: 1'b0, bits: word_r.bits};
        mid_nxt = 1'b0;
        case (state_r)
            RX_IDLE:
            begin
                cnt_nxt = '0;
                if (!rx)
                    state_nxt = RX_START;
            end
            RX_START:
            begin
                if (cnt_r == CNT_W'(HALF_CYC - 1))
                begin
                    // start bit is checked then dropped
                    cnt_nxt = '0;
                    nbit_nxt = '0;
                    state_nxt = rx ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA:
            begin
                if (cnt_r == CNT_W'(BIT_CYC - 1))
                begin
                    cnt_nxt = '0;
                    mid_nxt = 1'b1;
                    sr_nxt = {rx, sr_r[WORD_W-1:1]};
                    nbit_nxt = nbit_r + 1'b1;
                    if (nbit_r == 4'(WORD_W - 1))
                    begin
                        word_nxt = '{valid: 1'b1, bits: {rx, sr_r[WORD_W-1:1]}};
                        state_nxt = RX_IDLE;
                    end
                end
            end
            default:
                state_nxt = RX_IDLE;
        endcase
        if (!enable)
        begin
            state_nxt = RX_IDLE;
            word_nxt.valid = 1'b0;
            mid_nxt = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r <= RX_IDLE;
            cnt_r <= '0;
            nbit_r <= '0;
            sr_r <= '0;
            word_r <= '0;
            mid_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            nbit_r <= nbit_nxt;
            sr_r <= sr_nxt;
            word_r <= word_nxt;
            mid_r <= mid_nxt;
        end
    end

    assign mid_pulse = mid_r;
    assign word = word_r;
endmodule
`default_nettype wire

// file: rtl/cid_fsk_if.sv
// Purpose: caller data interface: stream or 9-bit buffer, flags, function select
// Assumes: analog front end delivers demod, carrier, tone and guard levels
// Notes: control pins live in an apb register
//
// Contract
// - mark frequency outputs logic one, space outputs logic zero
// - mode 0 puts the raw demodulated stream directly on data out
// - mode 1 drops start bit, stores eight data bits and stop bit
// - ninth shift clock presents the stored stop bit for framing check
// - ready output pulses low half a bit at each word end
// - mode 1 shift clock rising edge during ready low returns ready high
// - in tone functions the shared output is the delayed tone flag
// - early tone flag follows raw tone detection without time qualification
// - guard node above threshold asserts delayed flag, below releases it
// - carrier output low while carrier present, with dropout hysteresis
// - demodulated data suppressed until carrier indication is active
// - two function selects choose demod, line tone or hybrid tone
// - interface select high with both function selects low powers down
// - mode 0 drives shift clock marking each bit centre; here data and stop bits only, not the start bit
// - mode 1 shift clock pin is an input shifting buffered bits
// - 11 demod, 10 hybrid tone, 01 line tone
// - all three controls low is a factory test state
`timescale 1ns/1ps
`default_nettype none
module cid_fsk_if
    import cid_pkg::*;
#(
    parameter int unsigned BIT_CYC = BIT_CYC_DEF,
    parameter int unsigned HALF_CYC = HALF_CYC_DEF,
    parameter int unsigned CD_ON_CYC = CD_ON_CYC_DEF,
    parameter int unsigned CD_OFF_CYC = CD_OFF_CYC_DEF
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // front end levels
    input wire logic demod_bit,
    input wire logic carrier_raw,
    input wire logic tone_raw,
    input wire logic guard_threshold,
    // host pins
    input wire logic bit_shift_clock_i,
    output logic bit_shift_clock_o,
    output logic bit_shift_clock_oe_n,
    output logic data_out,
    output logic ready_or_tone_flag_n,
    output logic early_tone_flag,
    output logic carrier_present_n,
    // front end control
    output logic hybrid_amp_select,
    output logic power_down,
    output logic test_mode
);
    cid_ctrl_t ctrl_r, ctrl_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic [PIN_W-1:0] pins_s;
    cid_func_t func;
    logic mode1, demod_act, tone_act;
    logic mid_pulse;
    cid_word_t word;
    logic shift_ev, mapped;
    logic carrier_r, carrier_nxt;
    logic [CNT_W-1:0] cd_cnt_r, cd_cnt_nxt;
    logic [CNT_W-1:0] ck_cnt_r, ck_cnt_nxt;
    logic clk_out_r, clk_out_nxt;
    logic [CNT_W-1:0] dr_cnt_r, dr_cnt_nxt;
    logic dr_n_r, dr_n_nxt;
    logic [WORD_W-1:0] buf_r, buf_nxt;
    logic data_r, data_nxt;
    logic shclk_prev_r, shclk_prev_nxt;
    logic early_r, early_nxt;
    logic delayed_n_r, delayed_n_nxt;
    logic flag_n_r, flag_n_nxt;

    cid_sync #(.WIDTH(PIN_W)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in({bit_shift_clock_i, guard_threshold, tone_raw, carrier_raw, demod_bit}),
        .pin_sync(pins_s)
    );

    // function decode
    always_comb
    begin
        case ({ctrl_r.function_select_a, ctrl_r.function_select_b})
            2'b11: func = FN_DEMOD;
            2'b10: func = FN_HYB_TONE;
            2'b01: func = FN_LINE_TONE;
            default: func = ctrl_r.interface_select ? FN_POWER_DOWN : FN_TEST;
        endcase
    end

    assign mode1 = ctrl_r.interface_select;
    assign demod_act = (func == FN_DEMOD);
    assign tone_act = (func == FN_HYB_TONE) || (func == FN_LINE_TONE);
    assign shift_ev = demod_act && mode1 && pins_s[PIN_SHCLK] && !shclk_prev_r;
    assign mapped = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS) || (paddr == ADDR_WORD);

    cid_bitrx #(.BIT_CYC(BIT_CYC), .HALF_CYC(HALF_CYC)) u_rx (
        .pclk(pclk),
        .presetn(presetn),
        .enable(demod_act && carrier_r),
        .rx(pins_s[PIN_DEMOD]),
        .mid_pulse(mid_pulse),
        .word(word)
    );

    // apb registers
    always_comb
    begin
        ctrl_nxt = ctrl_r;
        prdata_nxt = prdata_r;
        if (psel && penable && pwrite && paddr == ADDR_CTRL)
            ctrl_nxt = cid_ctrl_t'(pwdata[2:0]);
        if (psel && !penable && !pwrite)
        begin
            case (paddr)
                ADDR_CTRL: prdata_nxt = {29'h0, ctrl_r};
                ADDR_STATUS:
                begin
                    prdata_nxt = 32'h0;
                    prdata_nxt[ST_CARRIER] = carrier_r;
                    prdata_nxt[ST_EARLY] = early_r;
                    prdata_nxt[ST_DELAYED] = !delayed_n_r;
                    prdata_nxt[ST_READY] = !dr_n_r;
                    prdata_nxt[ST_PDOWN] = (func == FN_POWER_DOWN);
                    prdata_nxt[ST_TEST] = (func == FN_TEST);
                end
                ADDR_WORD: prdata_nxt = {23'h0, buf_r};
                default: prdata_nxt = 32'h0;
            endcase
        end
    end

    // carrier qualification with hysteresis
    always_comb
    begin
        carrier_nxt = carrier_r;
        cd_cnt_nxt = '0;
        if (!demod_act)
            carrier_nxt = 1'b0;
        else if (pins_s[PIN_CARRIER] != carrier_r)
        begin
            cd_cnt_nxt = cd_cnt_r + 1'b1;
            if (carrier_r ? (cd_cnt_r == CNT_W'(CD_OFF_CYC - 1))
                          : (cd_cnt_r == CNT_W'(CD_ON_CYC - 1)))
            begin
                carrier_nxt = !carrier_r;
                cd_cnt_nxt = '0;
            end
        end
    end

    // mode 0 bit-centre clock
    always_comb
    begin
        clk_out_nxt = clk_out_r;
        ck_cnt_nxt = ck_cnt_r;
        if (mid_pulse && !mode1)
        begin
            clk_out_nxt = 1'b1;
            ck_cnt_nxt = '0;
        end
        else if (clk_out_r)
        begin
            ck_cnt_nxt = ck_cnt_r + 1'b1;
            if (ck_cnt_r == CNT_W'(HALF_CYC - 1))
                clk_out_nxt = 1'b0;
        end
    end

    // word ready pulse
    always_comb
    begin
        dr_n_nxt = dr_n_r;
        dr_cnt_nxt = dr_cnt_r;
        if (!demod_act)
            dr_n_nxt = 1'b1;
        else if (word.valid)
        begin
            dr_n_nxt = 1'b0;
            dr_cnt_nxt = '0;
        end
        else if (!dr_n_r)
        begin
            dr_cnt_nxt = dr_cnt_r + 1'b1;
            if (dr_cnt_r == CNT_W'(HALF_CYC - 1) || shift_ev)
                dr_n_nxt = 1'b1;
        end
    end

    // data path: stream or nine-bit buffer
    always_comb
    begin
        buf_nxt = buf_r;
        data_nxt = data_r;
        shclk_prev_nxt = pins_s[PIN_SHCLK];
        if (!demod_act)
            data_nxt = 1'b1;
        else if (!mode1)
            data_nxt = carrier_r ? pins_s[PIN_DEMOD] : 1'b1;
        else if (shift_ev)
        begin
            data_nxt = buf_r[0];
            buf_nxt = {1'b1, buf_r[WORD_W-1:1]};
        end
        if (demod_act && mode1 && word.valid)
            buf_nxt = word.bits;
    end

    // tone flags and shared output
    always_comb
    begin
        early_nxt = tone_act && pins_s[PIN_TONE];
        delayed_n_nxt = !(tone_act && pins_s[PIN_GUARD]);
        flag_n_nxt = demod_act ? dr_n_nxt : delayed_n_nxt;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_r <= cid_ctrl_t'(CTRL_RST);
            prdata_r <= 32'h0;
            carrier_r <= 1'b0;
            cd_cnt_r <= '0;
            clk_out_r <= 1'b0;
            ck_cnt_r <= '0;
            dr_n_r <= 1'b1;
            dr_cnt_r <= '0;
            buf_r <= '1;
            data_r <= 1'b1;
            shclk_prev_r <= 1'b0;
            early_r <= 1'b0;
            delayed_n_r <= 1'b1;
            flag_n_r <= 1'b1;
        end
        else
        begin
            ctrl_r <= ctrl_nxt;
            prdata_r <= prdata_nxt;
            carrier_r <= carrier_nxt;
            cd_cnt_r <= cd_cnt_nxt;
            clk_out_r <= clk_out_nxt;
            ck_cnt_r <= ck_cnt_nxt;
            dr_n_r <= dr_n_nxt;
            dr_cnt_r <= dr_cnt_nxt;
            buf_r <= buf_nxt;
            data_r <= data_nxt;
            shclk_prev_r <= shclk_prev_nxt;
            early_r <= early_nxt;
            delayed_n_r <= delayed_n_nxt;
            flag_n_r <= flag_n_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign bit_shift_clock_o = clk_out_r;
    assign bit_shift_clock_oe_n = !(demod_act && !mode1);
    assign data_out = data_r;
    assign ready_or_tone_flag_n = flag_n_r;
    assign early_tone_flag = early_r;
    assign carrier_present_n = !carrier_r;
    assign hybrid_amp_select = (func == FN_HYB_TONE);
    assign power_down = (func == FN_POWER_DOWN);
    assign test_mode = (func == FN_TEST);

    a_stream_data: assert property (@(posedge pclk) disable iff (!presetn)
        (demod_act && !mode1 && carrier_r && $stable(ctrl_r))
        |=> data_out == $past(pins_s[PIN_DEMOD]))
        else $error("stream data does not follow demodulator");
    a_gate_data: assert property (@(posedge pclk) disable iff (!presetn)
        (demod_act && !mode1 && !carrier_r) |=> data_out)
        else $error("data leaked without carrier");
    a_buffer_load: assert property (@(posedge pclk) disable iff (!presetn)
        (demod_act && mode1 && word.valid) |=> buf_r == $past(word.bits))
        else $error("buffer not loaded with new word");
    a_shift_lsb: assert property (@(posedge pclk) disable iff (!presetn)
        (shift_ev && !word.valid) |=> (data_out == $past(buf_r[0]))
        && (buf_r[WORD_W-2:0] == $past(buf_r[WORD_W-1:1])))
        else $error("shift did not advance one bit lsb first");
    a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        (demod_act && !mode1 && word.valid && $stable(ctrl_r))
        |=> !ready_or_tone_flag_n [*2])
        else $error("ready pulse missing or too short");
    a_ready_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (shift_ev && !dr_n_r && !word.valid) |=> dr_n_r ##1 ready_or_tone_flag_n)
        else $error("shift clock did not clear ready");
    a_early_tone: assert property (@(posedge pclk) disable iff (!presetn)
        (tone_act && pins_s[PIN_TONE]) |=> early_tone_flag)
        else $error("early tone flag missing");
    a_guard_tone: assert property (@(posedge pclk) disable iff (!presetn)
        (tone_act && $stable(ctrl_r)) |=> ready_or_tone_flag_n == !$past(pins_s[PIN_GUARD]))
        else $error("delayed tone flag does not follow guard");
    a_carrier_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (demod_act && carrier_r && !pins_s[PIN_CARRIER] && cd_cnt_r == '0)
        |=> !carrier_present_n)
        else $error("carrier released on first dropout cycle");
    a_power_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        (power_down && $past(power_down))
        |-> (!early_tone_flag && ready_or_tone_flag_n && carrier_present_n))
        else $error("activity during power down");
    a_mid_clock: assert property (@(posedge pclk) disable iff (!presetn)
        (mid_pulse && demod_act && !mode1) |=> bit_shift_clock_o && !bit_shift_clock_oe_n)
        else $error("bit centre clock not driven");
endmodule
`default_nettype wire

// file: rtl/cid_sync.sv
// Purpose: two-flop synchroniser for a group of pins
// Assumes: inputs are slow compared with pclk
// Notes: first stage is read only by the second
`timescale 1ns/1ps
`default_nettype none
module cid_sync
    import cid_pkg::*;
#(
    parameter int unsigned WIDTH = PIN_W
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // pins
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_sync
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    meta_r[i] <= 1'b0;
                    sync_r[i] <= 1'b0;
                end
                else
                begin
                    meta_r[i] <= pin_in[i];
                    sync_r[i] <= meta_r[i];
                end
            end
        end
    endgenerate

    assign pin_sync = sync_r;
endmodule
`default_nettype wire
